// File: logic/acc_edge.sv
/*
  Edge detector with mode qualification for the synchronised result.
  Assumes its input is already in the mclk_in domain.
*/
`timescale 1ns/10ps
module acc_edge (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic level_in,
  input wire logic [1:0] mode_in,
  output logic event_out
);
  logic prev_q;
  logic rise;
  logic fall;
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_in;
    end
  end
  assign rise = level_in & ~prev_q;
  assign fall = ~level_in & prev_q;
  always_comb begin
    case (acc_pkg::acc_mode_e'(mode_in))
      acc_pkg::ACC_MODE_TOGGLE: event_out = rise | fall;
      acc_pkg::ACC_MODE_FALL: event_out = fall;
      acc_pkg::ACC_MODE_RISE: event_out = rise;
      default: event_out = 1'b0; // Reserved code flags nothing
    endcase
  end
endmodule // acc_edge

// File: logic/acc_params.svh
/*
  Register offsets, field positions and reset values for the comparator control block.
  Assumes a byte-wide data-space bus on the core clock.
*/
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_IO_OFFSET 8'h20
`define ACC_AUX_ADDR 8'h4f
`define ACC_CSR_ADDR 8'h50
`define ACC_DID_ADDR 8'h7f
`define ACC_AUX_RESET 8'h00
`define ACC_CSR_RESET 8'h00
`define ACC_DID_RESET 8'h00
`define ACC_BIT_POWER_OFF 7
`define ACC_BIT_BANDGAP 6
`define ACC_BIT_RESULT 5
`define ACC_BIT_FLAG 4
`define ACC_BIT_IRQ_EN 3
`define ACC_BIT_CAPTURE 2
`define ACC_BIT_PIN_EN 0
`define ACC_BIT_POS_OFF 0
`define ACC_BIT_NEG_OFF 1
`endif

// File: logic/acc_pkg.sv
/*
  Types shared by the comparator control block.
  Assumes acc_params.svh is on the include path.
*/
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'b00,
    ACC_MODE_RESERVED = 2'b01,
    ACC_MODE_FALL = 2'b10,
    ACC_MODE_RISE = 2'b11
  } acc_mode_e;
  typedef logic [7:0] acc_byte_t;
endpackage

// File: logic/acc_sync.sv
/*
  Two flip-flop synchroniser for one level.
  Assumes the input is asynchronous to mclk_in.
*/
`timescale 1ns/10ps
module acc_sync (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic sync;
  } acc_sync_s;
  acc_sync_s st_q;
  acc_sync_s st_d;
  always_comb begin
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign sync_out = st_q.sync;
endmodule // acc_sync

// File: logic/acc_top.sv
/*
  Analog comparator control: registers, input selection, result sync, flag and routing.
  Assumes a byte-wide single-cycle data-space bus; the analog core, pins and timer are outside.
*/
`timescale 1ns/10ps
`include "acc_params.svh"
module acc_top (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic bus_io_space_in,
  input wire logic bus_write_in,
  input wire logic bus_read_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic compare_raw_in,
  input wire logic negative_mux_enable_in,
  input wire logic converter_enable_in,
  input wire logic [2:0] channel_select_low_in,
  input wire logic global_irq_enable_in,
  input wire logic irq_vector_ack_in,
  input wire logic positive_pin_in,
  input wire logic negative_pin_in,
  output logic [7:0] bus_rdata_out,
  output logic irq_out,
  output logic compare_power_off_out,
  output logic bandgap_select_out,
  output logic negative_use_mux_out,
  output logic [2:0] negative_channel_out,
  output logic capture_out,
  output logic result_pin_out,
  output logic result_pin_oe_out,
  output logic positive_pin_buffer_off_out,
  output logic negative_pin_buffer_off_out,
  output logic positive_pin_digital_out,
  output logic negative_pin_digital_out
);
  typedef struct packed {
    logic power_off;
    logic bandgap;
    logic flag;
    logic irq_en;
    logic capture_en;
    logic [1:0] mode;
    logic pin_en;
    logic pos_off;
    logic neg_off;
    logic [7:0] rdata;
    logic irq;
    logic use_mux;
    logic [2:0] channel;
    logic capture;
    logic pin;
    logic pin_oe;
    logic pos_dig;
    logic neg_dig;
  } acc_top_s;
  acc_top_s st_q;
  acc_top_s st_d;
  logic result_sync;
  logic pos_sync;
  logic neg_sync;
  logic event_hit;
  logic [7:0] eff_addr;
  logic hit_aux;
  logic hit_csr;
  logic hit_did;
  logic [7:0] csr_view;

  // Pins and analog output are asynchronous, so each crosses two flops
  acc_sync u_sync_result (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .async_in(compare_raw_in),
    .sync_out(result_sync)
  );
  acc_sync u_sync_pos (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .async_in(positive_pin_in),
    .sync_out(pos_sync)
  );
  acc_sync u_sync_neg (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .async_in(negative_pin_in),
    .sync_out(neg_sync)
  );
  acc_edge u_edge (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .level_in(result_sync),
    .mode_in(st_q.mode),
    .event_out(event_hit)
  );

  // I/O space sits 0x20 below data space
  assign eff_addr = bus_io_space_in ? 8'(bus_addr_in + `ACC_IO_OFFSET) : bus_addr_in;
  assign hit_aux = (eff_addr == `ACC_AUX_ADDR);
  assign hit_csr = (eff_addr == `ACC_CSR_ADDR);
  // Buffer-disable register has no short I/O alias
  assign hit_did = !bus_io_space_in && (bus_addr_in == `ACC_DID_ADDR);
  assign csr_view = {st_q.power_off, st_q.bandgap, result_sync, st_q.flag,
                     st_q.irq_en, st_q.capture_en, st_q.mode};

  always_comb begin
    st_d = st_q;
    if (bus_write_in && hit_csr) begin
      st_d.power_off = bus_wdata_in[`ACC_BIT_POWER_OFF];
      st_d.bandgap = bus_wdata_in[`ACC_BIT_BANDGAP];
      st_d.irq_en = bus_wdata_in[`ACC_BIT_IRQ_EN];
      st_d.capture_en = bus_wdata_in[`ACC_BIT_CAPTURE];
      st_d.mode = bus_wdata_in[1:0];
    end
    if (bus_write_in && hit_aux) begin
      st_d.pin_en = bus_wdata_in[`ACC_BIT_PIN_EN];
    end
    if (bus_write_in && hit_did) begin
      st_d.pos_off = bus_wdata_in[`ACC_BIT_POS_OFF];
      st_d.neg_off = bus_wdata_in[`ACC_BIT_NEG_OFF];
    end
    // Set wins over either clear so no event is lost
    if (irq_vector_ack_in || (bus_write_in && hit_csr && bus_wdata_in[`ACC_BIT_FLAG])) begin
      st_d.flag = 1'b0;
    end
    if (event_hit && !st_q.power_off) begin
      st_d.flag = 1'b1;
    end
    st_d.irq = st_d.flag && st_d.irq_en && global_irq_enable_in;
    st_d.rdata = 8'h00;
    if (bus_read_in && hit_csr) begin
      st_d.rdata = csr_view;
    end else if (bus_read_in && hit_aux) begin
      st_d.rdata = {7'h00, st_q.pin_en};
    end else if (bus_read_in && hit_did) begin
      st_d.rdata = {6'h00, st_q.neg_off, st_q.pos_off};
    end
    st_d.use_mux = negative_mux_enable_in && !converter_enable_in;
    st_d.channel = st_d.use_mux ? channel_select_low_in : 3'h0;
    st_d.capture = st_q.capture_en && result_sync;
    st_d.pin = result_sync && st_q.pin_en;
    st_d.pin_oe = st_q.pin_en;
    st_d.pos_dig = pos_sync && !st_q.pos_off;
    st_d.neg_dig = neg_sync && !st_q.neg_off;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_rdata_out = st_q.rdata;
  assign irq_out = st_q.irq;
  assign compare_power_off_out = st_q.power_off;
  assign bandgap_select_out = st_q.bandgap;
  assign negative_use_mux_out = st_q.use_mux;
  assign negative_channel_out = st_q.channel;
  assign capture_out = st_q.capture;
  assign result_pin_out = st_q.pin;
  assign result_pin_oe_out = st_q.pin_oe;
  assign positive_pin_buffer_off_out = st_q.pos_off;
  assign negative_pin_buffer_off_out = st_q.neg_off;
  assign positive_pin_digital_out = st_q.pos_dig;
  assign negative_pin_digital_out = st_q.neg_dig;

  // Assertions
  a_flag_on_event: assert property (@(posedge mclk_in) disable iff (reset_in)
    (event_hit && !st_q.power_off) |=> st_q.flag) else $error("flag not set on event");
  a_irq_gating: assert property (@(posedge mclk_in) disable iff (reset_in)
    irq_out |-> (st_q.flag && st_q.irq_en)) else $error("irq without cause");
  a_flag_w1c: assert property (@(posedge mclk_in) disable iff (reset_in)
    (bus_write_in && hit_csr && bus_wdata_in[4] && !event_hit) |=> !st_q.flag)
    else $error("flag not cleared by write one");
  a_flag_w0_keep: assert property (@(posedge mclk_in) disable iff (reset_in)
    (st_q.flag && !irq_vector_ack_in && !(bus_write_in && hit_csr && bus_wdata_in[4]))
    |=> st_q.flag) else $error("flag lost");
  a_vector_clear: assert property (@(posedge mclk_in) disable iff (reset_in)
    (irq_vector_ack_in && !event_hit) |=> !st_q.flag) else $error("vector clear failed");
  a_reserved_mode: assert property (@(posedge mclk_in) disable iff (reset_in)
    (st_q.mode == 2'b01) |-> !event_hit) else $error("reserved mode flagged");
  a_mux_select: assert property (@(posedge mclk_in) disable iff (reset_in)
    (negative_mux_enable_in && converter_enable_in) |=> !negative_use_mux_out)
    else $error("mux used with converter on");
  a_sync_delay: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(compare_raw_in) ##1 compare_raw_in |-> ##1 result_sync)
    else $error("sync delay wrong");
  a_capture_route: assert property (@(posedge mclk_in) disable iff (reset_in)
    !st_q.capture_en |=> !capture_out) else $error("capture routed while off");
  a_pin_drive: assert property (@(posedge mclk_in) disable iff (reset_in)
    result_pin_oe_out |-> $past(st_q.pin_en)) else $error("pin drive wrong");
  a_buffer_zero: assert property (@(posedge mclk_in) disable iff (reset_in)
    st_q.pos_off ##1 st_q.pos_off |-> !positive_pin_digital_out)
    else $error("disabled input read one");
  a_io_alias: assert property (@(posedge mclk_in) disable iff (reset_in)
    (bus_read_in && bus_io_space_in && bus_addr_in == 8'h30) |=> bus_rdata_out[3:0] ==
    $past(csr_view[3:0])) else $error("io alias read wrong");
endmodule // acc_top

// File: sim/acc_core_model.sv
/*
  Behavioural analog core: input selection and comparison.
  Assumes the bench sets levels as 8-bit codes.
*/
`timescale 1ns/10ps
module acc_core_model #(
  parameter logic [7:0] BANDGAP_LEVEL = 8'h80
) (
  input wire logic power_off_in,
  input wire logic bandgap_select_in,
  input wire logic use_mux_in,
  input wire logic [2:0] channel_in,
  input wire logic [7:0] pos_level_in,
  input wire logic [7:0] neg_level_in,
  input wire logic [63:0] adc_level_in,
  output logic raw_out
);
  logic [7:0] pos_v;
  logic [7:0] neg_v;
  always_comb begin
    pos_v = bandgap_select_in ? BANDGAP_LEVEL : pos_level_in;
    neg_v = use_mux_in ? adc_level_in[channel_in*8 +: 8] : neg_level_in;
    // Powered-off core idles low
    raw_out = !power_off_in && (pos_v > neg_v);
  end
endmodule // acc_core_model

// File: sim/analog_comparator_control_tb.sv
/*
  Self-checking bench for the comparator control block.
  Assumes the analog core model drives the raw result.
*/
`timescale 1ns/10ps
module analog_comparator_control_tb;
  logic clk, rst, io, wr, rd, mux_en, conv_en, gie, ack, ppin, npin, raw;
  logic [7:0] addr, wdata, rdata, rdo, pos_lv, neg_lv;
  logic [2:0] chan, nchan;
  logic [63:0] adc_lv;
  logic irq, off, bg, use_mux, cap, rpin, roe, pbo, nbo, pdig, ndig;
  int n_fail, checked;
  acc_core_model i_core (.power_off_in(off), .bandgap_select_in(bg), .use_mux_in(use_mux),
    .channel_in(nchan), .pos_level_in(pos_lv), .neg_level_in(neg_lv),
    .adc_level_in(adc_lv), .raw_out(raw));
  acc_top i_dut (.mclk_in(clk), .reset_in(rst), .bus_addr_in(addr), .bus_io_space_in(io),
    .bus_write_in(wr), .bus_read_in(rd), .bus_wdata_in(wdata), .compare_raw_in(raw),
    .negative_mux_enable_in(mux_en), .converter_enable_in(conv_en),
    .channel_select_low_in(chan), .global_irq_enable_in(gie), .irq_vector_ack_in(ack),
    .positive_pin_in(ppin), .negative_pin_in(npin), .bus_rdata_out(rdo), .irq_out(irq),
    .compare_power_off_out(off), .bandgap_select_out(bg), .negative_use_mux_out(use_mux),
    .negative_channel_out(nchan), .capture_out(cap), .result_pin_out(rpin),
    .result_pin_oe_out(roe), .positive_pin_buffer_off_out(pbo),
    .negative_pin_buffer_off_out(nbo), .positive_pin_digital_out(pdig),
    .negative_pin_digital_out(ndig));
  task automatic print_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One strobe cycle; read data is taken in the cycle after the sampling edge
  task automatic acc(input logic [7:0] a, input logic i, input logic w, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    io = i;
    wr = w;
    rd = !w;
    wdata = d;
    @(negedge clk);
    wr = 0;
    rd = 0;
    rdata = rdo;
  endtask
  task automatic t_reset;
    acc(8'h4f, 0, 0, 0); chk(rdata, 8'h00);
    acc(8'h50, 0, 0, 0); chk(rdata, 8'h00);
    acc(8'h7f, 0, 0, 0); chk(rdata, 8'h00);
    acc(8'h51, 0, 1, 8'hff);
    acc(8'h51, 0, 0, 0); chk(rdata, 8'h00);
  endtask
  task automatic t_alias;
    acc(8'h2f, 1, 1, 8'hff);
    acc(8'h4f, 0, 0, 0); chk(rdata, 8'h01);
    chk({7'h0, roe}, 8'h01);
    acc(8'h30, 1, 1, 8'h40);
    cyc(4); // Bandgap settle time before trusting the result
    acc(8'h50, 0, 0, 0); chk(rdata, 8'h70);
    acc(8'h5f, 1, 0, 0); chk(rdata, 8'h00);
    acc(8'h50, 0, 1, 8'h00);
  endtask
  task automatic t_mux;
    pos_lv = 8'h80;
    // Converter enable is held at zero outside this block
    mux_en = 1;
    for (int ch = 0; ch < 8; ch++) begin
      chan = ch[2:0];
      adc_lv = 64'hff << (ch * 8);
      cyc(4);
      chk({use_mux, 4'h0, nchan}, {5'h10, ch[2:0]});
      acc(8'h50, 0, 0, 0); chk(rdata & 8'h20, 8'h00);
    end
    conv_en = 1;
    cyc(4);
    chk({7'h0, use_mux}, 8'h00);
    acc(8'h50, 0, 0, 0); chk(rdata & 8'h20, 8'h20);
    {pos_lv, mux_en, conv_en} = '0;
    cyc(4);
  endtask
  // Every mode code, then a rise and a fall, each cleared by a written one
  task automatic t_modes;
    logic [1:0] m;
    logic up, dn;
    for (int k = 0; k < 4; k++) begin
      m = k[1:0];
      up = (m == acc_pkg::ACC_MODE_TOGGLE) || (m == acc_pkg::ACC_MODE_RISE);
      dn = (m == acc_pkg::ACC_MODE_TOGGLE) || (m == acc_pkg::ACC_MODE_FALL);
      acc(8'h50, 0, 1, {6'h04, m}); // Enable stays off while the mode changes
      pos_lv = 8'h80;
      cyc(5);
      chk({7'h0, rpin}, 8'h01);
      acc(8'h50, 0, 0, 0); chk(rdata, {2'b00, 1'b1, up, 2'b00, m});
      acc(8'h50, 0, 1, {6'h04, m});
      acc(8'h50, 0, 0, 0); chk(rdata, {6'h08, m});
      pos_lv = 8'h00;
      cyc(5);
      acc(8'h50, 0, 0, 0); chk(rdata, {3'b000, dn, 2'b00, m});
    end
  endtask
  task automatic t_irq;
    acc(8'h50, 0, 1, 8'h13);
    acc(8'h50, 0, 1, 8'h0b);
    pos_lv = 8'h80;
    cyc(5);
    chk({7'h0, irq}, 8'h00);
    gie = 1;
    cyc(2);
    chk({7'h0, irq}, 8'h01);
    ack = 1;
    cyc(1);
    ack = 0;
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    acc(8'h50, 0, 0, 0); chk(rdata, 8'h2b);
    pos_lv = 8'h00;
    cyc(4);
    pos_lv = 8'h80;
    cyc(5);
    acc(8'h50, 0, 1, 8'h0b);
    acc(8'h50, 0, 0, 0); chk(rdata, 8'h3b);
    acc(8'h50, 0, 1, 8'h13);
    gie = 0;
  endtask
  // Power-off drops the raw result; no flag while off, toggle flag once back on
  task automatic t_cap_off;
    acc(8'h50, 0, 1, 8'h14);
    cyc(2);
    chk({7'h0, cap}, 8'h01);
    acc(8'h50, 0, 1, 8'h80);
    cyc(5);
    chk({6'h0, off, cap}, 8'h02);
    acc(8'h50, 0, 0, 0); chk(rdata, 8'h80);
    acc(8'h50, 0, 1, 8'h00);
    cyc(5);
    acc(8'h50, 0, 0, 0); chk(rdata, 8'h30);
  endtask
  task automatic t_did;
    ppin = 1;
    npin = 1;
    cyc(4);
    chk({6'h0, ndig, pdig}, 8'h03);
    acc(8'h7f, 0, 1, 8'hff);
    acc(8'h7f, 0, 0, 0); chk(rdata, 8'h03);
    chk({4'h0, nbo, pbo, ndig, pdig}, 8'h0c);
    acc(8'h7f, 0, 1, 8'h01);
    cyc(4);
    chk({4'h0, nbo, pbo, ndig, pdig}, 8'h06);
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Tests take under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    {rst, io, wr, rd, mux_en, conv_en, gie, ack, ppin, npin} = 10'h200;
    {addr, wdata, pos_lv, chan, adc_lv} = '0;
    neg_lv = 8'h40;
    n_fail = 0;
    checked = 0;
    cyc(6);
    rst = 0;
    t_reset();
    t_alias();
    t_mux();
    t_modes();
    t_irq();
    t_cap_off();
    t_did();
    print_verdict();
  end
endmodule // analog_comparator_control_tb
